// ### common/sch_params.svh
`ifndef SCH_PARAMS_SVH
`define SCH_PARAMS_SVH

// Channel bus width
`define SCH_CHAN_W          8
// Least trigger pulse width in ns
`define SCH_TRIG_MIN_NS     1000
// Typical trigger response time in ns
`define SCH_RESP_TYP_NS     60000
// Clock period in ns
`define SCH_CLK_NS          5
// Least pulse width in cycles, rounded up
`define SCH_TRIG_MIN_CYC    ((`SCH_TRIG_MIN_NS + `SCH_CLK_NS - 1) / `SCH_CLK_NS)
// Response time in cycles, rounded down
`define SCH_RESP_CYC        (`SCH_RESP_TYP_NS / `SCH_CLK_NS)
// Register offsets
`define SCH_OFS_CTRL        4'h0
`define SCH_OFS_STATUS      4'h1
`define SCH_OFS_IRQ_STAT    4'h2
`define SCH_OFS_IRQ_MASK    4'h3
// Control field positions
`define SCH_CTRL_MULTI_BIT  0
`define SCH_CTRL_MODE_LSB   1
`define SCH_CTRL_ANA_BIT    3
`define SCH_CTRL_CYC_BIT    4
// Interrupt bit positions
`define SCH_IRQ_TRIG_BIT    0
`define SCH_IRQ_ANA_BIT     1
`define SCH_IRQ_CYC_BIT     2
// Reset values
`define SCH_CTRL_RST        5'h00
`define SCH_MASK_RST        3'h0

`endif

// ### common/sch_pkg.sv
package sch_pkg;

  // Trigger source modes
  typedef enum logic [1:0]
  {
    SCH_TRIG_INT,
    SCH_TRIG_MAN,
    SCH_TRIG_PIN,
    SCH_TRIG_BUS
  } sch_mode_t;

  // Measurement progress
  typedef enum logic [1:0]
  {
    SCH_IDLE,
    SCH_ANALOG,
    SCH_FINISH
  } sch_state_t;

endpackage

// ### src/sch_sync.sv
`timescale 1ns/100ps
`include "sch_params.svh"

module sch_sync
  import sch_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rstn,
  // Raw pins
  input  wire logic [`SCH_CHAN_W-1:0] chan_sel_n,
  input  wire logic                   chan_sel_valid_n,
  input  wire logic                   hw_trigger_in,
  // Synchronised levels and edge
  output logic      [`SCH_CHAN_W-1:0] chan_s,
  output logic                        valid_s,
  output logic                        trig_rise
);

  typedef struct packed
  {
    logic [`SCH_CHAN_W-1:0] ch1;
    logic [`SCH_CHAN_W-1:0] ch2;
    logic                   v1;
    logic                   v2;
    logic                   t1;
    logic                   t2;
    logic                   t3;
  } sch_sync_t;

  sch_sync_t s_q;
  sch_sync_t s_d;

  // Two stages per pin, a third on the trigger for the edge; idle pins read high for active-low lines
  always_comb
  begin
    s_d     = s_q;
    s_d.ch1 = chan_sel_n;
    s_d.ch2 = s_q.ch1;
    s_d.v1  = chan_sel_valid_n;
    s_d.v2  = s_q.v1;
    s_d.t1  = hw_trigger_in;
    s_d.t2  = s_q.t1;
    s_d.t3  = s_q.t2; // Edge detector reads only second stage onward
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      s_q <= '{ch1: 8'hFF, ch2: 8'hFF, v1: 1'b1, v2: 1'b1,
               t1: 1'b0, t2: 1'b0, t3: 1'b0};
    else
      s_q <= s_d;
  end

  // Decode: low line means bit value 1
  assign chan_s    = ~s_q.ch2; // RQ11 RQ1
  assign valid_s   = ~s_q.v2; // RQ10
  assign trig_rise = s_q.t2 & ~s_q.t3; // RQ14

endmodule

// ### src/sch_handshake.sv
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "sch_params.svh"

// Overview of operation
// RQ1: The channel number arrives on eight lines, top line the MSB, bottom line the LSB.
// RQ2: A trigger taken while channel-valid is low loads the channel lines as active channel.
// RQ3: Analog-done goes low when the analog part of a triggered measurement is over.
// RQ4: The scanner may step to its next channel once analog-done is low.
// RQ5: The controller must not read results before cycle-done is low.
// RQ6: Cycle-done goes low when the whole measurement is over and its data is ready.
// RQ7: The trigger pin counts only in pin trigger mode and is ignored otherwise.
// RQ8: A measurement starts on a trigger rising edge; pulses last at least 1 us.
// RQ9: Both done outputs answer a trigger within a typical 60 us.
// RQ10: Every signal named with a leading slash is active low.
// RQ11: A channel line reads as 0 when high and 1 when low.
// RQ12: With multi-correction off the channel inputs are ignored and both outputs stay low.
// RQ13: The scanner drops valid, sets the channel, raises valid, then triggers.
// RQ14: All scanner inputs are synchronised and each trigger edge is counted once.
// RQ15: A new trigger raises both done outputs until their own completion event.

module sch_handshake
  import sch_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rstn,
  // Scanner pins
  input  wire logic [`SCH_CHAN_W-1:0] chan_sel_n,
  input  wire logic                   chan_sel_valid_n,
  input  wire logic                   hw_trigger_in,
  output logic                        analog_done_n,
  output logic                        cycle_done_n,
  // Measurement core
  input  wire logic                   analog_end,
  input  wire logic                   cycle_end,
  output logic                        meas_start,
  output logic      [`SCH_CHAN_W-1:0] active_chan,
  // Register port
  input  wire logic [3:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  output logic                        irq
);

  typedef struct packed
  {
    sch_state_t             st;
    logic [4:0]             ctrl;
    logic [2:0]             istat;
    logic [2:0]             imask;
    logic [`SCH_CHAN_W-1:0] chan;
    logic                   ana_n;
    logic                   cyc_n;
    logic                   start;
    logic [31:0]            rdata;
  } sch_regs_t;

  localparam logic [31:0] RESP_CYC = 32'(`SCH_RESP_CYC);

  sch_regs_t r_q;
  sch_regs_t r_d;

  logic [`SCH_CHAN_W-1:0] chan_s;
  logic                   valid_s;
  logic                   trig_rise;
  logic                   multi_on;
  logic                   pin_mode;
  logic                   trig_ok;
  logic                   ana_ev;
  logic                   cyc_ev;
  logic [31:0]            resp_cnt_q;

  // Bit mask helper for clear-on-one
  function automatic logic [2:0] sch_w1c(input logic [2:0] cur, input logic [2:0] set,
                                         input logic [2:0] clr);
    sch_w1c = (cur & ~clr) | set; // Set wins over clear
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  // Pin synchroniser and edge detector
  sch_sync u_sync
  (
    .clk              (clk),
    .rstn             (rstn),
    .chan_sel_n       (chan_sel_n),
    .chan_sel_valid_n (chan_sel_valid_n),
    .hw_trigger_in    (hw_trigger_in),
    .chan_s           (chan_s),
    .valid_s          (valid_s),
    .trig_rise        (trig_rise)
  );

  // Mode decode from control register
  assign multi_on = r_q.ctrl[`SCH_CTRL_MULTI_BIT];
  assign pin_mode = (sch_mode_t'(r_q.ctrl[`SCH_CTRL_MODE_LSB +: 2]) == SCH_TRIG_PIN); // RQ7
  assign trig_ok  = trig_rise & pin_mode; // RQ7 RQ8
  // Completion from the core, only while a measurement runs
  assign ana_ev   = (r_q.st == SCH_ANALOG) & analog_end;
  assign cyc_ev   = (r_q.st == SCH_FINISH) & cycle_end;

  ////////////////////////////////////////////////////////////////////////////////

  // Measurement sequence, registers and pins
  always_comb
  begin
    r_d       = r_q;
    r_d.start = 1'b0;
    r_d.rdata = 32'h0;
    case (r_q.st)
      SCH_IDLE:
      begin
        if (trig_ok)
        begin
          r_d.st    = SCH_ANALOG;
          r_d.start = 1'b1; // RQ8
          r_d.ana_n = 1'b1; // RQ15
          r_d.cyc_n = 1'b1; // RQ15
          // Channel taken only when valid and correction is on
          if (valid_s && multi_on)
            r_d.chan = chan_s; // RQ2 RQ13
        end
      end
      SCH_ANALOG:
      begin
        if (ana_ev)
        begin
          r_d.st    = SCH_FINISH;
          r_d.ana_n = 1'b0; // RQ3 RQ9
        end
      end
      SCH_FINISH:
      begin
        if (cyc_ev)
        begin
          r_d.st    = SCH_IDLE;
          r_d.cyc_n = 1'b0; // RQ6 RQ9
        end
      end
      default:
      begin
        r_d.st = SCH_IDLE;
      end
    endcase
    // Correction off: outputs pinned low
    if (!multi_on)
    begin
      r_d.ana_n = 1'b0; // RQ12
      r_d.cyc_n = 1'b0; // RQ12
    end
    // Register writes
    if (reg_wr)
    begin
      case (reg_addr)
        `SCH_OFS_CTRL:     r_d.ctrl  = reg_wdata[4:0];
        `SCH_OFS_IRQ_MASK: r_d.imask = reg_wdata[2:0];
        default:           r_d.ctrl  = r_d.ctrl;
      endcase
    end
    // Only a trigger taken from idle counts as accepted
    r_d.istat = sch_w1c(r_q.istat, {cyc_ev, ana_ev, trig_ok & (r_q.st == SCH_IDLE)},
                        (reg_wr && reg_addr == `SCH_OFS_IRQ_STAT) ? reg_wdata[2:0] : 3'h0);
    // Read data stands one cycle after the strobe
    if (reg_rd)
    begin
      case (reg_addr)
        `SCH_OFS_CTRL:     r_d.rdata = {27'h0, r_q.ctrl};
        `SCH_OFS_STATUS:   r_d.rdata = {20'h0, r_q.chan, r_q.st, r_q.cyc_n, r_q.ana_n};
        `SCH_OFS_IRQ_STAT: r_d.rdata = {29'h0, r_q.istat};
        `SCH_OFS_IRQ_MASK: r_d.rdata = {29'h0, r_q.imask};
        default:           r_d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      r_q <= '{st: SCH_IDLE, ctrl: `SCH_CTRL_RST, istat: 3'h0, imask: `SCH_MASK_RST,
               chan: 8'h00, ana_n: 1'b0, cyc_n: 1'b0, start: 1'b0, rdata: 32'h0};
    else
      r_q <= r_d;
  end

  // Outputs straight from flip-flops; irq is the OR of the masked flags
  assign analog_done_n = r_q.ana_n;
  assign cycle_done_n  = r_q.cyc_n;
  assign meas_start    = r_q.start;
  assign active_chan   = r_q.chan;
  assign reg_rdata     = r_q.rdata;
  assign irq           = |(r_q.istat & r_q.imask);

  ////////////////////////////////////////////////////////////////////////////////

  // Busy cycles since the last start, held in idle, checking only
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      resp_cnt_q <= 32'h0;
    else if (r_q.start)
      resp_cnt_q <= 32'h0;
    else if (r_q.st != SCH_IDLE)
      resp_cnt_q <= resp_cnt_q + 32'h1;
  end

  // Triggers while busy are dropped, so only idle ones are accepted
  sequence s_accept;
    trig_ok && multi_on && r_q.st == SCH_IDLE;
  endsequence

  sequence s_raise;
    analog_done_n && cycle_done_n && meas_start;
  endsequence

  a_trig_raises_done: assert property (@(posedge clk) disable iff (!rstn) // RQ15
    s_accept |=> s_raise)
    else $error("trigger did not raise both done outputs");

  a_trig_needs_pin: assert property (@(posedge clk) disable iff (!rstn) // RQ7
    $rose(meas_start) |-> $past(pin_mode))
    else $error("measurement started outside pin trigger mode");

  a_chan_latched: assert property (@(posedge clk) disable iff (!rstn) // RQ2
    (trig_ok && valid_s && multi_on && r_q.st == SCH_IDLE) |=> (active_chan == $past(chan_s)))
    else $error("channel not adopted on trigger");

  a_chan_holds: assert property (@(posedge clk) disable iff (!rstn) // RQ12
    (!trig_ok || !valid_s || !multi_on) |=> $stable(active_chan))
    else $error("channel changed without valid trigger");

  a_analog_done: assert property (@(posedge clk) disable iff (!rstn) // RQ3
    (ana_ev && multi_on) |=> !analog_done_n && cycle_done_n)
    else $error("analog done not asserted");

  a_cycle_done: assert property (@(posedge clk) disable iff (!rstn) // RQ6
    (cyc_ev && multi_on) |=> !cycle_done_n ##1 (!cycle_done_n || meas_start))
    else $error("cycle done not asserted");

  a_off_low: assert property (@(posedge clk) disable iff (!rstn) // RQ12
    !multi_on |=> !analog_done_n && !cycle_done_n)
    else $error("outputs not low with correction off");

  a_order_done: assert property (@(posedge clk) disable iff (!rstn) // RQ5
    (multi_on && $fell(cycle_done_n)) |-> !analog_done_n)
    else $error("cycle done before analog done");

  a_edge_once: assert property (@(posedge clk) disable iff (!rstn) // RQ14
    trig_rise |-> $past(hw_trigger_in, 2) && !$past(hw_trigger_in, 3))
    else $error("trigger edge counted twice");

  a_resp_window: assert property (@(posedge clk) disable iff (!rstn) // RQ9
    (r_q.st == SCH_ANALOG && multi_on) |-> resp_cnt_q < RESP_CYC)
    else $error("analog done late beyond response time");

endmodule

// ### verif/sch_scan_model.sv
`timescale 1ns/100ps
`include "sch_params.svh"

module sch_scan_model
(
  // Clock
  input  wire logic                   clk,
  // Scanner pins
  output logic      [`SCH_CHAN_W-1:0] chan_sel_n,
  output logic                        chan_sel_valid_n,
  output logic                        hw_trigger_in
);
  // Idle: trigger pin grounded, valid off
  initial
  begin
    chan_sel_n       = '1;
    chan_sel_valid_n = 1'b1;
    hw_trigger_in    = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Select a channel, then pulse the trigger; en low leaves valid off
  task automatic scan(input logic [7:0] ch, input logic en, input int width);
    @(posedge clk);
    chan_sel_valid_n <= 1'b1;
    chan_sel_n       <= ~ch;
    @(posedge clk);
    chan_sel_valid_n <= ~en;
    @(posedge clk);
    hw_trigger_in    <= 1'b1;
    repeat (width) @(posedge clk);
    hw_trigger_in    <= 1'b0;
    // Released lines show the inverse so a stale value cannot pass
    chan_sel_valid_n <= 1'b1;
    chan_sel_n       <= ch;
  endtask
endmodule

// ### verif/tb_top.sv
`timescale 1ns/100ps
`include "sch_params.svh"

module tb_top;
  import sch_pkg::*;
  localparam int TRIG_CYC = `SCH_TRIG_MIN_CYC;
  logic                   clk, rstn, chan_sel_valid_n, hw_trigger_in;
  logic [`SCH_CHAN_W-1:0] chan_sel_n, active_chan;
  logic                   analog_done_n, cycle_done_n, analog_end, cycle_end;
  logic                   meas_start, reg_wr, reg_rd, irq, seen;
  logic [3:0]             reg_addr;
  logic [31:0]            reg_wdata, reg_rdata, rdat;
  int                     error_cnt = 0;
  int                     n_compared = 0;
  // Rows: channel driven, channel expected
  logic [15:0]            rows [5] = '{16'h0101, 16'h8080, 16'hFFFF, 16'h0000, 16'hA5A5};
  logic [1:0]             modes [3] = '{2'h0, 2'h1, 2'h3};

  sch_scan_model u_sch_scan_model (.clk(clk), .chan_sel_n(chan_sel_n),
    .chan_sel_valid_n(chan_sel_valid_n), .hw_trigger_in(hw_trigger_in));
  sch_handshake u_sch_handshake (.clk(clk), .rstn(rstn), .chan_sel_n(chan_sel_n),
    .chan_sel_valid_n(chan_sel_valid_n), .hw_trigger_in(hw_trigger_in),
    .analog_done_n(analog_done_n), .cycle_done_n(cycle_done_n), .analog_end(analog_end),
    .cycle_end(cycle_end), .meas_start(meas_start), .active_chan(active_chan),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));

  // Clock
  initial
  begin
    clk = 1'b0;
  end
  always #2.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Register port: one-cycle strobes, read data the cycle after
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    rdat = reg_rdata;
  endtask

  // Launch a scan and watch a bounded window for the start pulse
  task automatic fire(input logic [7:0] ch, input logic en);
    fork
      u_sch_scan_model.scan(ch, en, TRIG_CYC);
    join_none
    seen = 1'b0;
    for (int i = 0; i < 20 && !seen; i++)
    begin
      @(posedge clk);
      #1;
      seen = (meas_start === 1'b1);
    end
  endtask

  // One-cycle completion pulse from the core
  task automatic done_pulse(input logic cyc);
    @(posedge clk);
    analog_end <= ~cyc;
    cycle_end  <= cyc;
    @(posedge clk);
    analog_end <= 1'b0;
    cycle_end  <= 1'b0;
    #1;
  endtask

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rstn = 1'b0;
    {analog_end, cycle_end, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk("done pair", 2'b00, {analog_done_n, cycle_done_n});
    rd(`SCH_OFS_CTRL);
    chk("ctrl", 32'h0, rdat);
    rd(`SCH_OFS_IRQ_MASK);
    chk("mask", 32'h0, rdat);
    rd(4'hF);
    chk("unmapped", 32'h0, rdat);
    wr(`SCH_OFS_CTRL, 32'h5);
    wr(`SCH_OFS_IRQ_MASK, 32'h4);
    // Ordinary cases
    foreach (rows[i])
    begin
      fire(rows[i][15:8], 1'b1);
      chk("meas_start", 1'b1, seen);
      chk("active_chan", rows[i][7:0], active_chan);
      chk("done pair", 2'b11, {analog_done_n, cycle_done_n});
      done_pulse(1'b1);
      chk("done pair", 2'b11, {analog_done_n, cycle_done_n});
      done_pulse(1'b0);
      chk("done pair", 2'b01, {analog_done_n, cycle_done_n});
      chk("irq", 1'b0, irq);
      done_pulse(1'b1);
      chk("done pair", 2'b00, {analog_done_n, cycle_done_n});
      chk("irq", 1'b1, irq);
      rd(`SCH_OFS_STATUS);
      chk("status", {rows[i][7:0], 2'b00}, {rdat[11:4], rdat[1:0]});
      rd(`SCH_OFS_IRQ_STAT);
      chk("irq stat", 32'h7, rdat);
      wr(`SCH_OFS_IRQ_STAT, 32'h7);
      rd(`SCH_OFS_IRQ_STAT);
      chk("irq stat", 32'h0, rdat);
      chk("irq", 1'b0, irq);
      repeat (TRIG_CYC) @(posedge clk);
    end
    // Valid left off: channel kept, measurement still runs
    fire(8'h3C, 1'b0);
    chk("meas_start", 1'b1, seen);
    chk("active_chan", 8'hA5, active_chan);
    done_pulse(1'b0);
    repeat (TRIG_CYC) @(posedge clk);
    // Scanner steps on after analog done; its trigger while busy is dropped
    fire(8'h5A, 1'b1);
    chk("meas_start", 1'b0, seen);
    chk("active_chan", 8'hA5, active_chan);
    chk("done pair", 2'b01, {analog_done_n, cycle_done_n});
    done_pulse(1'b1);
    chk("done pair", 2'b00, {analog_done_n, cycle_done_n});
    repeat (TRIG_CYC) @(posedge clk);
    // Other trigger modes ignore the pin
    foreach (modes[i])
    begin
      wr(`SCH_OFS_CTRL, {29'h0, modes[i], 1'b1});
      fire(8'h11, 1'b1);
      chk("meas_start", 1'b0, seen);
      repeat (TRIG_CYC) @(posedge clk);
    end
    // Correction off: outputs held low, channel ignored
    wr(`SCH_OFS_CTRL, 32'h4);
    fire(8'h22, 1'b1);
    chk("meas_start", 1'b1, seen);
    chk("done pair", 2'b00, {analog_done_n, cycle_done_n});
    chk("active_chan", 8'hA5, active_chan);
    repeat (TRIG_CYC) @(posedge clk);
    // Second reset mid-run
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk("active_chan", 8'h00, active_chan);
    chk("done pair", 2'b00, {analog_done_n, cycle_done_n});
    conclude();
  end
endmodule
